// ### tb/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host controller model, mode 0, clock still between frames
// ==========================================================================
module flash_host_model (
  // Link pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  // Last reply byte
  output logic [7:0] rx_byte
);
  event rx_done;
  // Pins at time zero, chip select held low until it rises at 1 ns
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    rx_byte = 8'h00;
    #1 cs_n = 1'b1; // Clean rising edge clears the link side
  end
  // One frame: nb bytes out MSB first, then nr reply bits in
  task automatic frame(input logic [23:0] tx, input int nb, input int nr);
    int i;
    #7 cs_n = 1'b0;
    for (i = 0; i < 8 * nb + nr; i++) begin
      si = (i < 8 * nb) ? tx[8 * nb - 1 - i] : ~si;
      #80 sck = 1'b1;
      rx_byte = {rx_byte[6:0], so};
      #80 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    si = ~si; // Released line shows no held value
    if (nr > 0) -> rx_done;
    #100;
  endtask
endmodule // flash_host_model
`default_nettype wire

// ### tb/flash_param_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checker
// ==========================================================================
module flash_param_sva #(
  parameter int ADDR_W = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link pins
  input wire logic so_oe,
  // Core side
  input wire logic sw_reset,
  input wire logic [7:0] nv_read_params,
  input wire logic [2:0] nv_drive_strength,
  input wire flash_param_pkg::nv_write_t nv_write,
  input wire logic wrap_enable_bit,
  input wire logic [1:0] wrap_size,
  input wire logic [3:0] dummy_cycles,
  input wire logic pin_function_select_bit,
  input wire logic [2:0] drive_strength,
  input wire logic powered_down,
  input wire logic cmd_ready,
  input wire logic rd_start,
  input wire logic [ADDR_W-1:0] rd_start_addr,
  input wire logic rd_advance,
  input wire logic [ADDR_W-1:0] rd_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] cfg;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] wrap_next;
  logic [9:0] rec_cnt;
  logic [9:0] next_rec_cnt;
  // Working byte and wrapped address step
  assign cfg = {pin_function_select_bit, dummy_cycles, wrap_enable_bit, wrap_size};
  assign mask = (ADDR_W'(8) << wrap_size) - ADDR_W'(1);
  assign wrap_next = (rd_addr & ~mask) | ((rd_addr + ADDR_W'(1)) & mask);
  // Recovery stretch length
  always_comb begin
    next_rec_cnt = (!cmd_ready && !powered_down) ? rec_cnt + 10'h001 : 10'h000;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rec_cnt <= 10'h000;
    end else begin
      rec_cnt <= next_rec_cnt;
    end
  end
  AST_STATE_EXCL: assert property (!(powered_down && cmd_ready))
    else $error("power-down and ready together");
  AST_RECOVERY_MIN: assert property ($rose(cmd_ready) |-> rec_cnt >= 10'h2E9)
    else $error("recovery ended early");
  AST_RECOVERY_MAX: assert property (rec_cnt <= 10'h2FD)
    else $error("recovery too long");
  AST_ADDR_LOAD: assert property (rd_start |=> rd_addr == $past(rd_start_addr))
    else $error("start address not loaded");
  AST_ADDR_LINEAR: assert property (rd_advance && !rd_start && !wrap_enable_bit
    |=> rd_addr == $past(rd_addr) + ADDR_W'(1)) else $error("linear step wrong");
  AST_ADDR_WRAP: assert property (rd_advance && !rd_start && wrap_enable_bit
    |=> rd_addr == $past(wrap_next)) else $error("wrap step wrong");
  AST_ADDR_HOLD: assert property (!rd_start && !rd_advance |=> $stable(rd_addr))
    else $error("address moved");
  AST_NVW_PULSE: assert property (nv_write.valid |=> !nv_write.valid)
    else $error("write pulse too long");
  AST_NV_READ: assert property (nv_write.valid && !nv_write.ext_sel
    |=> cfg == $past(nv_write.data)) else $error("working copy not set");
  AST_NV_EXT: assert property (nv_write.valid && nv_write.ext_sel
    |=> drive_strength == $past(nv_write.data[7:5])) else $error("drive not set");
  AST_SW_RELOAD: assert property (sw_reset |-> ##[1:2]
    (cfg == nv_read_params && drive_strength == nv_drive_strength))
    else $error("reload missing");
  AST_PD_QUIET: assert property (powered_down && $past(powered_down)
    |-> $stable(cfg) && $stable(drive_strength) && !so_oe) else $error("active in power-down");
endmodule // flash_param_sva
bind flash_read_param_config flash_param_sva #(.ADDR_W(ADDR_W)) i_sva (
  .clk(clk), .arst_n(arst_n), .so_oe(so_oe), .sw_reset(sw_reset),
  .nv_read_params(nv_read_params), .nv_drive_strength(nv_drive_strength),
  .nv_write(nv_write), .wrap_enable_bit(wrap_enable_bit), .wrap_size(wrap_size),
  .dummy_cycles(dummy_cycles), .pin_function_select_bit(pin_function_select_bit),
  .drive_strength(drive_strength), .powered_down(powered_down), .cmd_ready(cmd_ready),
  .rd_start(rd_start), .rd_start_addr(rd_start_addr), .rd_advance(rd_advance),
  .rd_addr(rd_addr));
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench
// ==========================================================================
module testbench;
  localparam int AW = 22;
  logic clk = 1'b0;
  logic arst_n, sck, cs_n, si, so, so_oe, write_in_progress_flag, sw_reset;
  logic [7:0] nv_read_params, rx_byte, rp, cfg;
  logic [2:0] nv_drive_strength, drive_strength;
  flash_param_pkg::nv_write_t nv_write;
  logic wrap_enable_bit, pin_function_select_bit, powered_down, cmd_ready;
  logic [1:0] wrap_size;
  logic [3:0] dummy_cycles;
  logic rd_start, rd_advance;
  logic [AW-1:0] rd_start_addr, rd_addr;
  logic [7:0] exp_q[$];
  logic [15:0] lfsr = 16'h0016;
  logic [9:0] nv_last;
  logic oe_seen = 1'b0;
  int fails = 0, checked = 0, nvw_cnt = 0, n;
  assign cfg = {pin_function_select_bit, dummy_cycles, wrap_enable_bit, wrap_size};
  // Core clock
  always #2 clk = ~clk;
  flash_read_param_config #(.ADDR_W(AW)) i_dut (
    .clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .write_in_progress_flag(write_in_progress_flag), .sw_reset(sw_reset),
    .nv_read_params(nv_read_params), .nv_drive_strength(nv_drive_strength),
    .nv_write(nv_write), .wrap_enable_bit(wrap_enable_bit), .wrap_size(wrap_size),
    .dummy_cycles(dummy_cycles), .pin_function_select_bit(pin_function_select_bit),
    .drive_strength(drive_strength), .powered_down(powered_down), .cmd_ready(cmd_ready),
    .rd_start(rd_start), .rd_start_addr(rd_start_addr), .rd_advance(rd_advance),
    .rd_addr(rd_addr));
  flash_host_model i_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .rx_byte(rx_byte));
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("Counts: fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic setp(input logic [7:0] op, input logic [7:0] v);
    i_host.frame({8'h00, op, v}, 2, 0);
  endtask
  task automatic cmd(input logic [7:0] op);
    i_host.frame({16'h0000, op}, 1, 0);
  endtask
  task automatic rb(input logic [7:0] op, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.frame({16'h0000, op}, 1, 8);
  endtask
  // Address walk against the wrap window
  task automatic walk(input logic [7:0] v, input logic [AW-1:0] a0, input int steps);
    logic [AW-1:0] e, m;
    int i;
    m = (AW'(8) << v[1:0]) - AW'(1);
    @(negedge clk);
    rd_start = 1'b1;
    rd_start_addr = a0;
    e = a0;
    @(negedge clk);
    rd_start = 1'b0;
    rd_advance = 1'b1;
    check(rd_addr, e);
    for (i = 0; i < steps; i++) begin
      @(negedge clk);
      e = v[2] ? ((e & ~m) | ((e + AW'(1)) & m)) : e + AW'(1);
      check(rd_addr, e);
    end
    rd_advance = 1'b0;
  endtask
  // Write log and reply enable watch
  always @(posedge clk) if (nv_write.valid === 1'b1) begin
    nvw_cnt++;
    nv_last = nv_write;
  end
  always @(posedge so_oe) oe_seen = 1'b1;
  // Reply monitor takes the oldest expectation
  always @(i_host.rx_done) begin
    if (exp_q.size() == 0) check(32'h1, 32'h0);
    else check(rx_byte, exp_q.pop_front());
  end
  // Watchdog
  initial begin
    #200000;
    fails++;
    close_out;
  end
  // Main sequence
  initial begin
    arst_n = 1'b0;
    write_in_progress_flag = 1'b0;
    sw_reset = 1'b0;
    rd_start = 1'b0;
    rd_advance = 1'b0;
    rd_start_addr = '0;
    lfsr = lfsr_step(lfsr);
    nv_read_params = lfsr[7:0];
    nv_drive_strength = lfsr[10:8];
    repeat (3) @(negedge clk);
    check(drive_strength, flash_param_pkg::DRIVE_HALF);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    check(cfg, nv_read_params);
    check(drive_strength, nv_drive_strength);
    rb(flash_param_pkg::OP_RB_RD, nv_read_params);
    rb(flash_param_pkg::OP_RB_EXT, {nv_drive_strength, 5'h00});
    for (n = 0; n < 8; n++) begin
      lfsr = lfsr_step(lfsr);
      rp = {lfsr[7:3], n[2:0]};
      setp(n[0] ? flash_param_pkg::OP_SET_RD_V_A : flash_param_pkg::OP_SET_RD_V_B, rp);
      check(wrap_enable_bit, rp[2]);
      check(cfg, rp);
      rb(flash_param_pkg::OP_RB_RD, rp);
      walk(rp, {lfsr[5:0], lfsr}, 70);
    end
    check(nvw_cnt, 0);
    rp = lfsr[15:8];
    setp(flash_param_pkg::OP_SET_RD_NV, rp);
    check(nv_last, {2'b10, rp});
    rb(flash_param_pkg::OP_RB_RD, rp);
    setp(flash_param_pkg::OP_SET_EXT_NV, {lfsr[2:0], 5'h00});
    check(nv_last, {2'b11, lfsr[2:0], 5'h00});
    check(drive_strength, lfsr[2:0]);
    setp(flash_param_pkg::OP_SET_EXT_V, {~lfsr[2:0], 5'h00});
    check(nvw_cnt, 2);
    rb(flash_param_pkg::OP_RB_EXT, {~lfsr[2:0], 5'h00});
    i_host.frame({flash_param_pkg::OP_SET_RD_V_B, 16'hFFFF}, 3, 0);
    rb(flash_param_pkg::OP_RB_RD, rp);
    @(negedge clk) write_in_progress_flag = 1'b1;
    setp(flash_param_pkg::OP_SET_RD_NV, 8'h00);
    check(nvw_cnt, 2);
    setp(flash_param_pkg::OP_SET_EXT_V, {lfsr[2:0], 5'h00});
    rb(flash_param_pkg::OP_RB_EXT, {lfsr[2:0], 5'h01});
    cmd(flash_param_pkg::OP_POWER_DOWN);
    check(powered_down, 1'b0);
    @(negedge clk) write_in_progress_flag = 1'b0;
    cmd(flash_param_pkg::OP_POWER_DOWN);
    check({powered_down, cmd_ready}, 2'b10);
    setp(flash_param_pkg::OP_SET_RD_V_B, ~rp);
    oe_seen = 1'b0;
    cmd(flash_param_pkg::OP_RB_RD);
    check(oe_seen, 1'b0);
    @(negedge clk) write_in_progress_flag = 1'b1;
    cmd(flash_param_pkg::OP_RELEASE);
    check(powered_down, 1'b1);
    @(negedge clk) write_in_progress_flag = 1'b0;
    cmd(flash_param_pkg::OP_RELEASE);
    check(powered_down, 1'b0);
    n = 0;
    // Chip select high until ready returns
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check(n >= 715, 1'b1);
    check(cmd_ready, 1'b1);
    rb(flash_param_pkg::OP_RB_RD, rp);
    @(negedge clk) sw_reset = 1'b1;
    @(negedge clk) sw_reset = 1'b0;
    repeat (2) @(negedge clk);
    rb(flash_param_pkg::OP_RB_RD, nv_read_params);
    rb(flash_param_pkg::OP_RB_EXT, {nv_drive_strength, 5'h00});
    repeat (10) @(negedge clk);
    close_out;
  end
endmodule // testbench
`default_nettype wire

// ### verilog/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Two-stage level synchroniser
// ============================================================================
module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Level
  input wire logic d,
  output logic q
);

  logic meta;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // bit_sync
`default_nettype wire

// ### verilog/flash_param_pkg.sv
`default_nettype none
package flash_param_pkg;

  // ==========================================================================
  // Opcodes
  // ==========================================================================
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_SET_RD_NV = 8'h65;
  localparam logic [7:0] OP_SET_RD_V_A = 8'hC0;
  localparam logic [7:0] OP_SET_RD_V_B = 8'h63;
  localparam logic [7:0] OP_SET_EXT_NV = 8'h85;
  localparam logic [7:0] OP_SET_EXT_V = 8'h83;
  localparam logic [7:0] OP_RB_RD = 8'h61;
  localparam logic [7:0] OP_RB_EXT = 8'h81;

  // ==========================================================================
  // Read parameter layout
  // ==========================================================================
  localparam int WRAP_SIZE_LSB = 0;
  localparam int WRAP_SIZE_W = 2;
  localparam int WRAP_EN_BIT = 2;
  localparam int DUMMY_LSB = 3;
  localparam int DUMMY_W = 4;
  localparam int PIN_SEL_BIT = 7;
  localparam int WRAP_BASE_BYTES = 8;

  // ==========================================================================
  // Extended parameter layout
  // ==========================================================================
  localparam int DRIVE_LSB = 5;
  localparam int DRIVE_W = 3;
  localparam int EXT_WIP_BIT = 0;
  localparam logic [2:0] DRIVE_HALF = 3'h5;
  localparam logic [7:0] RD_RESET = 8'h00;

  // ==========================================================================
  // Frame positions and timing
  // ==========================================================================
  localparam logic [1:0] IDX_OPCODE = 2'h0;
  localparam logic [1:0] IDX_DATA = 2'h1;
  localparam logic [1:0] IDX_MAX = 2'h3;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RELEASE_RECOVERY_NS = 3000;
  localparam int RELEASE_RECOVERY_CYCLES =
    (RELEASE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_W = 12;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {ST_ACTIVE, ST_POWER_DOWN, ST_RECOVERY} pwr_state_t;

  typedef struct packed {
    logic [1:0] index;
    logic [7:0] data;
  } link_byte_t;

  typedef struct packed {
    logic en;
    logic [7:0] data;
  } reply_t;

  typedef struct packed {
    logic valid;
    logic ext_sel;
    logic [7:0] data;
  } nv_write_t;

endpackage
`default_nettype wire

// ### verilog/flash_read_param_config.sv
// Contract
// - A framed lone release opcode leaves deep power-down.
// - After release, ignore instructions until recovery time elapses.
// - Release opcode during a write is ignored, ongoing cycle untouched.
// - Read params: wrap bits 2..0, dummy bits 6..3, pin select bit 7.
// - Bit 7 selects hold or reset function of the shared pin.
// - Persistent and working set-read-params; working one sets working copy only.
// - Persistent set-read-params also writes the working read parameters.
// - Bit 2 enables wrap, bits 1..0 pick 8/16/32/64 aligned in a page.
// - Without wrap the read address increments across the whole array.
// - With wrap, start byte first, then wrap to window start until deselect.
// - Values 00h..03h give linear reads, 04h..07h give 8..64 byte wrap.
// - Wrap persists until cleared by a set command, power-down or reset; here power-down keeps the working read parameters.
// - Every read follows wrap addressing while wrap is enabled.
// - Extended params hold a 3-bit drive strength field.
// - Drive strength defaults to the half-strength encoding.
// - Persistent set-ext writes both copies, working set-ext writes working only.
// - Read-params readback returns the working copy only.
// - Extended readback returns the working copy only.
// - Extended readback is served during a write.
// - In deep power-down only the release opcode is recognised.
// - Software reset reloads working copies from persistent ones.
`timescale 1ns/1ps
`default_nettype none
module flash_read_param_config #(
  parameter int ADDR_W = 22,
  parameter logic [2:0] DRIVE_DEFAULT = flash_param_pkg::DRIVE_HALF
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Status and control from the core
  input wire logic write_in_progress_flag,
  input wire logic sw_reset,
  // Persistent parameter storage
  input wire logic [7:0] nv_read_params,
  input wire logic [2:0] nv_drive_strength,
  output flash_param_pkg::nv_write_t nv_write,
  // Configuration outputs
  output logic wrap_enable_bit,
  output logic [1:0] wrap_size,
  output logic [3:0] dummy_cycles,
  output logic pin_function_select_bit,
  output logic [2:0] drive_strength,
  output logic powered_down,
  output logic cmd_ready,
  // Read address generator
  input wire logic rd_start,
  input wire logic [ADDR_W-1:0] rd_start_addr,
  input wire logic rd_advance,
  output logic [ADDR_W-1:0] rd_addr
);

  // ==========================================================================
  // Link domain and crossings
  // ==========================================================================
  flash_param_pkg::link_byte_t rx_byte;
  flash_param_pkg::reply_t reply;
  logic rx_toggle;
  logic toggle_sync;
  logic toggle_prev;
  logic cs_sync;
  logic cs_prev;

  // Serial shifter on the link clock
  spi_link_shifter u_link (
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .rx_byte(rx_byte),
    .rx_toggle(rx_toggle),
    .reply(reply)
  );

  // Byte toggle into the core domain
  bit_sync #(.RESET_VAL(1'b0)) u_toggle_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(rx_toggle),
    .q(toggle_sync)
  );

  // Chip select into the core domain, idle high
  bit_sync #(.RESET_VAL(1'b1)) u_cs_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(cs_n),
    .q(cs_sync)
  );

  logic byte_event;
  logic frame_start;
  logic frame_end;

  // Edges seen on the synchronised copies only
  assign byte_event = toggle_sync ^ toggle_prev;
  assign frame_start = cs_prev & ~cs_sync;
  assign frame_end = cs_sync & ~cs_prev;

  // ==========================================================================
  // Frame capture
  // ==========================================================================
  logic [7:0] opcode;
  logic [7:0] param;
  logic [1:0] last_index;
  logic got_opcode;
  logic [7:0] next_opcode;
  logic [7:0] next_param;
  logic [1:0] next_last_index;
  logic next_got_opcode;
  flash_param_pkg::reply_t next_reply;

  // Working copies
  logic [7:0] read_params;
  logic [2:0] ext_drive;
  flash_param_pkg::pwr_state_t state;

  // Opcode, data byte and early readback byte of the frame
  always_comb begin
    next_opcode = opcode;
    next_param = param;
    next_last_index = last_index;
    next_got_opcode = got_opcode;
    next_reply = reply;
    if (frame_start) begin
      next_got_opcode = 1'b0;
      next_reply = '{en: 1'b0, data: 8'h00};
    end else if (byte_event && rx_byte.index != flash_param_pkg::IDX_MAX) begin
      next_last_index = rx_byte.index;
      if (rx_byte.index == flash_param_pkg::IDX_OPCODE) begin
        next_opcode = rx_byte.data;
        next_got_opcode = 1'b1;
        if (state == flash_param_pkg::ST_ACTIVE) begin
          if (rx_byte.data == flash_param_pkg::OP_RB_RD) begin
            next_reply = '{en: 1'b1, data: read_params};
          end else if (rx_byte.data == flash_param_pkg::OP_RB_EXT) begin
            // Served during writes too
            next_reply.en = 1'b1;
            next_reply.data = 8'h00;
            next_reply.data[flash_param_pkg::DRIVE_LSB +: flash_param_pkg::DRIVE_W] =
              ext_drive;
            next_reply.data[flash_param_pkg::EXT_WIP_BIT] = write_in_progress_flag;
          end
        end
      end else if (rx_byte.index == flash_param_pkg::IDX_DATA) begin
        next_param = rx_byte.data;
      end
    end
  end

  // Frame capture registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      toggle_prev <= 1'b0;
      cs_prev <= 1'b1;
      opcode <= 8'h00;
      param <= 8'h00;
      last_index <= flash_param_pkg::IDX_OPCODE;
      got_opcode <= 1'b0;
      reply <= '{en: 1'b0, data: 8'h00};
    end else begin
      toggle_prev <= toggle_sync;
      cs_prev <= cs_sync;
      opcode <= next_opcode;
      param <= next_param;
      last_index <= next_last_index;
      got_opcode <= next_got_opcode;
      reply <= next_reply;
    end
  end

  // ==========================================================================
  // Command execution and power state
  // ==========================================================================
  localparam int RECOVERY_W_L = flash_param_pkg::RECOVERY_W;
  logic [RECOVERY_W_L-1:0] recovery_cnt;
  logic [RECOVERY_W_L-1:0] next_recovery_cnt;
  flash_param_pkg::pwr_state_t next_state;
  logic [7:0] next_read_params;
  logic [2:0] next_ext_drive;
  flash_param_pkg::nv_write_t next_nv_write;
  logic load_pending;
  logic next_load_pending;
  logic lone_opcode;
  logic one_data;
  logic set_rd_v;

  assign lone_opcode = frame_end & got_opcode & (last_index == flash_param_pkg::IDX_OPCODE);
  assign one_data = frame_end & got_opcode & (last_index == flash_param_pkg::IDX_DATA);
  assign set_rd_v = (opcode == flash_param_pkg::OP_SET_RD_V_A) |
                    (opcode == flash_param_pkg::OP_SET_RD_V_B);

  // Next power state, working copies and persistent write requests
  always_comb begin
    next_state = state;
    next_recovery_cnt = recovery_cnt;
    next_read_params = read_params;
    next_ext_drive = ext_drive;
    next_nv_write = '{valid: 1'b0, ext_sel: 1'b0, data: 8'h00};
    next_load_pending = 1'b0;
    case (state)
      flash_param_pkg::ST_ACTIVE: begin
        if (lone_opcode && opcode == flash_param_pkg::OP_POWER_DOWN &&
            !write_in_progress_flag) begin
          next_state = flash_param_pkg::ST_POWER_DOWN;
        end else if (one_data) begin
          if (opcode == flash_param_pkg::OP_SET_RD_NV && !write_in_progress_flag) begin
            next_read_params = param;
            next_nv_write = '{valid: 1'b1, ext_sel: 1'b0, data: param};
          end else if (set_rd_v) begin
            next_read_params = param;
          end else if (opcode == flash_param_pkg::OP_SET_EXT_NV &&
                       !write_in_progress_flag) begin
            next_ext_drive = param[flash_param_pkg::DRIVE_LSB +: flash_param_pkg::DRIVE_W];
            next_nv_write = '{valid: 1'b1, ext_sel: 1'b1, data: param};
          end else if (opcode == flash_param_pkg::OP_SET_EXT_V) begin
            next_ext_drive = param[flash_param_pkg::DRIVE_LSB +: flash_param_pkg::DRIVE_W];
          end
        end
      end
      flash_param_pkg::ST_POWER_DOWN: begin
        // Only a lone release opcode counts here
        if (lone_opcode && opcode == flash_param_pkg::OP_RELEASE &&
            !write_in_progress_flag) begin
          next_state = flash_param_pkg::ST_RECOVERY;
          next_recovery_cnt = RECOVERY_W_L'(flash_param_pkg::RELEASE_RECOVERY_CYCLES - 1);
        end
      end
      flash_param_pkg::ST_RECOVERY: begin
        // Frames ignored until the count runs out
        if (recovery_cnt == '0) begin
          next_state = flash_param_pkg::ST_ACTIVE;
        end else begin
          next_recovery_cnt = recovery_cnt - 1'b1;
        end
      end
      default: begin
        next_state = flash_param_pkg::ST_ACTIVE;
      end
    endcase
    // Reload from persistent copies after power-up and on software reset
    if (load_pending || sw_reset) begin
      next_read_params = nv_read_params;
      next_ext_drive = nv_drive_strength;
    end
  end

  // Power state, working copies and request registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= flash_param_pkg::ST_ACTIVE;
      recovery_cnt <= '0;
      read_params <= flash_param_pkg::RD_RESET;
      ext_drive <= DRIVE_DEFAULT;
      nv_write <= '{valid: 1'b0, ext_sel: 1'b0, data: 8'h00};
      load_pending <= 1'b1;
    end else begin
      state <= next_state;
      recovery_cnt <= next_recovery_cnt;
      read_params <= next_read_params;
      ext_drive <= next_ext_drive;
      nv_write <= next_nv_write;
      load_pending <= next_load_pending;
    end
  end

  // ==========================================================================
  // Configuration outputs
  // ==========================================================================
  // Fields of the working read parameters, drive strength and power state
  assign wrap_enable_bit = read_params[flash_param_pkg::WRAP_EN_BIT];
  assign wrap_size = read_params[flash_param_pkg::WRAP_SIZE_LSB +: flash_param_pkg::WRAP_SIZE_W];
  assign dummy_cycles = read_params[flash_param_pkg::DUMMY_LSB +: flash_param_pkg::DUMMY_W];
  assign pin_function_select_bit = read_params[flash_param_pkg::PIN_SEL_BIT];
  assign drive_strength = ext_drive;
  assign powered_down = (state == flash_param_pkg::ST_POWER_DOWN);
  assign cmd_ready = (state == flash_param_pkg::ST_ACTIVE);

  // ==========================================================================
  // Read address generator
  // ==========================================================================
  logic [ADDR_W-1:0] wrap_mask;
  logic [ADDR_W-1:0] addr_plus;
  logic [ADDR_W-1:0] next_rd_addr;

  // Window mask of 8 to 64 bytes, inside one page
  assign wrap_mask = ADDR_W'((flash_param_pkg::WRAP_BASE_BYTES << wrap_size) - 1);
  assign addr_plus = rd_addr + 1'b1;

  // Start address first, then linear or wrapped stepping
  always_comb begin
    next_rd_addr = rd_addr;
    if (rd_start) begin
      next_rd_addr = rd_start_addr;
    end else if (rd_advance) begin
      if (wrap_enable_bit) begin
        next_rd_addr = (rd_addr & ~wrap_mask) | (addr_plus & wrap_mask);
      end else begin
        next_rd_addr = addr_plus;
      end
    end
  end

  // Read address register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr <= '0;
    end else begin
      rd_addr <= next_rd_addr;
    end
  end

endmodule // flash_read_param_config
`default_nettype wire

// ### verilog/spi_link_shifter.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Link-side serial shifter, cleared by chip select
// ============================================================================
module spi_link_shifter (
  // Link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Toward the core domain
  output flash_param_pkg::link_byte_t rx_byte,
  output logic rx_toggle,
  // From the core domain, stable in the frame
  input wire flash_param_pkg::reply_t reply
);

  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] shift_out;
  logic [1:0] next_index;

  localparam logic [1:0] IDX_EXTRA = flash_param_pkg::IDX_DATA + 2'h1;

  assign next_index = (rx_byte.index == flash_param_pkg::IDX_MAX) ? flash_param_pkg::IDX_OPCODE :
    (rx_byte.index == IDX_EXTRA) ? IDX_EXTRA : rx_byte.index + 2'h1;

  // Sample input bits MSB first; chip select high ends the frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 3'h0;
      shift_in <= 7'h00;
      rx_byte <= '{index: flash_param_pkg::IDX_MAX, data: 8'h00};
      rx_toggle <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= {shift_in[5:0], si};
      if (bit_cnt == 3'h7) begin
        rx_byte <= '{index: next_index, data: {shift_in, si}};
        rx_toggle <= ~rx_toggle; // Byte event, payload held 8 link clocks
      end
    end
  end

  // Drive reply bits on falling edges, reload per byte
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      shift_out <= 8'h00;
      so_oe <= 1'b0;
    end else if (bit_cnt == 3'h0 && rx_byte.index != flash_param_pkg::IDX_MAX) begin
      shift_out <= reply.data;
      so_oe <= reply.en;
    end else begin
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  assign so = shift_out[7];

endmodule // spi_link_shifter
`default_nettype wire
